// >>> logic/nhic_top.sv
/*
 * Flash host interrupt status, interrupt enable, command port and
 * address port, with the cycle generator that drives the flash pins.
 * Assumes a register master on core_clk, event pulses from same-clock
 * logic, and asynchronous ready/busy and card-detect pins.
 */
`timescale 1ns/1ps
`include "nhic_consts.svh"

module nhic_top
    import nhic_pkg::*;
(
    input  wire logic        core_clk,         // core clock, 20 MHz
    input  wire logic        rst_n,            // sync reset, active low
    input  wire logic [31:0] bus_addr,         // register byte address
    input  wire logic [31:0] bus_wdata,        // write data
    input  wire logic        bus_wr,           // write strobe
    input  wire logic        bus_rd,           // read strobe
    output logic      [31:0] bus_rdata,        // read data, cycle after rd
    input  wire logic        xfer_done,        // transfer engine done pulse
    input  wire logic        code_mismatch,    // read code mismatch pulse
    input  wire logic        ready_busy_pin,   // flash ready/busy pin
    input  wire logic        slot0_detect_pin, // slot 0 card detect pin
    input  wire logic        slot1_detect_pin, // slot 1 card detect pin
    output logic             irq,              // interrupt, active high
    output logic             flash_cle,        // command latch enable
    output logic             flash_ale,        // address latch enable
    output logic             flash_we_n,       // flash write strobe
    output logic      [7:0]  flash_io_out,     // flash bus byte
    output logic             flash_io_oe       // flash bus driven
);
    logic [2:0]  pin_s1_r;      // first synchroniser stage
    logic [2:0]  pin_s2_r;      // second stage: rb, slot1, slot0
    logic [2:0]  pin_prev_r;    // previous synchronised levels
    logic [2:0]  warm_r;        // history valid after reset
    logic [10:0] flag_r;
    logic [10:0] flag_nxt;
    logic [10:0] ien_r;
    logic [10:0] event_vec;
    logic [10:0] clr_vec;
    logic        ready_busy_level;
    logic        slot1_detect_level;
    logic        slot0_detect_level;
    logic        ready_rise;
    logic        slot0_change;
    logic        slot1_change;
    logic        wr_ien;
    logic        wr_stat;
    logic        wr_cmd;
    logic        wr_addr;
    logic        gen_busy;
    logic        gen_start;

    // decode of a byte address against one register
    function automatic logic hit(input logic [31:0] a, input logic [31:0] reg_a);
        hit = (a == reg_a);
    endfunction

    assign wr_ien  = bus_wr && hit(bus_addr, `NHIC_IEN_ADDR);
    assign wr_stat = bus_wr && hit(bus_addr, `NHIC_STAT_ADDR);
    assign wr_cmd  = bus_wr && hit(bus_addr, `NHIC_CMD_ADDR);
    assign wr_addr = bus_wr && hit(bus_addr, `NHIC_ADDR_ADDR);

    // pins are asynchronous: two flops before anything looks at them
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pin_s1_r <= 3'h0;
            pin_s2_r <= 3'h0;
        end else begin
            pin_s1_r <= {ready_busy_pin, slot1_detect_pin, slot0_detect_pin};
            pin_s2_r <= pin_s1_r;
        end
    end

    // edge history; warm_r masks the false edge out of reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pin_prev_r <= 3'h0;
            warm_r     <= 3'h0;
        end else begin
            pin_prev_r <= pin_s2_r;
            warm_r     <= {warm_r[1:0], 1'b1};
        end
    end

    assign ready_busy_level   = pin_s2_r[2];
    assign slot1_detect_level = pin_s2_r[1];
    assign slot0_detect_level = pin_s2_r[0];
    assign ready_rise   = warm_r[2] && pin_s2_r[2] && !pin_prev_r[2];
    assign slot1_change = warm_r[2] && (pin_s2_r[1] != pin_prev_r[1]);
    assign slot0_change = warm_r[2] && (pin_s2_r[0] != pin_prev_r[0]);

    // hardware events into flag positions
    always_comb begin
        event_vec = 11'h000;
        event_vec[`NHIC_XFER_BIT]  = xfer_done;
        event_vec[`NHIC_CODE_BIT]  = code_mismatch;
        event_vec[`NHIC_RISE_BIT]  = ready_rise;
        // card changes are recorded only while their enable is on
        event_vec[`NHIC_SLOT0_BIT] = slot0_change && ien_r[`NHIC_SLOT0_BIT];
        event_vec[`NHIC_SLOT1_BIT] = slot1_change && ien_r[`NHIC_SLOT1_BIT];
    end

    // write-one-to-clear; an event in the clearing cycle wins
    always_comb begin
        clr_vec  = wr_stat ? bus_wdata[10:0] : 11'h000;
        flag_nxt = ((flag_r & ~clr_vec) | event_vec) & `NHIC_FLAG_MASK;
    end

    // sticky interrupt flags
    always_ff @(posedge core_clk) begin
        if (!rst_n) flag_r <= `NHIC_FLAG_RST;
        else flag_r <= flag_nxt;
    end

    // interrupt enable register; reserved bits stay zero
    always_ff @(posedge core_clk) begin
        if (!rst_n) ien_r <= `NHIC_IEN_RST;
        else if (wr_ien) ien_r <= bus_wdata[10:0] & `NHIC_FLAG_MASK;
    end

    // level interrupt, one flop behind the flags
    always_ff @(posedge core_clk) begin
        if (!rst_n) irq <= 1'b0;
        else irq <= |(flag_r & ien_r);
    end

    // read port: data stands the cycle after the strobe only
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bus_rdata <= 32'h00000000;
        end else if (bus_rd && hit(bus_addr, `NHIC_IEN_ADDR)) begin
            bus_rdata <= {21'h000000, ien_r};
        end else if (bus_rd && hit(bus_addr, `NHIC_STAT_ADDR)) begin
            bus_rdata <= 32'h00000000;
            bus_rdata[10:0] <= flag_r;
            bus_rdata[`NHIC_LVLRB_BIT] <= ready_busy_level;
            bus_rdata[`NHIC_LVL1_BIT]  <= slot1_detect_level;
            bus_rdata[`NHIC_LVL0_BIT]  <= slot0_detect_level;
        end else begin
            // write-only ports, unmapped addresses and idle cycles read zero
            bus_rdata <= 32'h00000000;
        end
    end

    // a port write while a cycle runs is dropped: the bus never waits
    assign gen_start = (wr_cmd || wr_addr) && !gen_busy;

    nhic_cycle_gen u_cycle_gen (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .start    (gen_start),
        .is_addr  (wr_addr),
        .last     (bus_wdata[`NHIC_LAST_BIT]),
        .data     (bus_wdata[7:0]),
        .busy     (gen_busy),
        .cle_o    (flash_cle),
        .ale_o    (flash_ale),
        .we_n_o   (flash_we_n),
        .io_o     (flash_io_out),
        .io_oe    (flash_io_oe)
    );

    // checks on the status register
    rb_mirror_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        bus_rd && hit(bus_addr, `NHIC_STAT_ADDR)
        |=> bus_rdata[`NHIC_LVLRB_BIT] == $past(pin_s2_r[2]))
        else $error("status ready level does not follow the pin");

    slot1_level_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        bus_rd && hit(bus_addr, `NHIC_STAT_ADDR)
        |=> bus_rdata[`NHIC_LVL1_BIT] == $past(pin_s2_r[1]))
        else $error("status slot 1 level does not follow the pin");

    slot0_level_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        bus_rd && hit(bus_addr, `NHIC_STAT_ADDR)
        |=> bus_rdata[`NHIC_LVL0_BIT] == $past(pin_s2_r[0]))
        else $error("status slot 0 level does not follow the pin");

    rise_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        warm_r[2] && pin_s2_r[2] && !pin_prev_r[2]
        |=> flag_r[`NHIC_RISE_BIT])
        else $error("ready rising edge not flagged");

    rise_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !flag_r[`NHIC_RISE_BIT] && !(pin_s2_r[2] && !pin_prev_r[2])
        |=> !flag_r[`NHIC_RISE_BIT])
        else $error("ready flag set without a rising edge");

    w1c_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_stat && bus_wdata[`NHIC_XFER_BIT] && !xfer_done
        |=> !flag_r[`NHIC_XFER_BIT])
        else $error("write of one did not clear the done flag");

    no_sw_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_stat && !flag_r[`NHIC_CODE_BIT] && !code_mismatch
        |=> !flag_r[`NHIC_CODE_BIT])
        else $error("software write set the mismatch flag");

    set_wins_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_stat && bus_wdata[`NHIC_XFER_BIT] && xfer_done
        |=> flag_r[`NHIC_XFER_BIT])
        else $error("done event lost against a clear");

    slot1_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !ien_r[`NHIC_SLOT1_BIT] && !flag_r[`NHIC_SLOT1_BIT]
        |=> !flag_r[`NHIC_SLOT1_BIT])
        else $error("slot 1 change recorded while disabled");

    slot0_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !ien_r[`NHIC_SLOT0_BIT] && !flag_r[`NHIC_SLOT0_BIT]
        |=> !flag_r[`NHIC_SLOT0_BIT])
        else $error("slot 0 change recorded while disabled");

    slot0_seen_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ien_r[`NHIC_SLOT0_BIT] && warm_r[2] && (pin_s2_r[0] != pin_prev_r[0])
        |=> flag_r[`NHIC_SLOT0_BIT])
        else $error("enabled slot 0 change not recorded");

    code_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        code_mismatch |=> flag_r[`NHIC_CODE_BIT])
        else $error("code mismatch not flagged");

    done_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        xfer_done |=> flag_r[`NHIC_XFER_BIT])
        else $error("transfer completion not flagged");

    // checks on the interrupt output
    irq_level_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ##1 irq == $past(|(flag_r & ien_r)))
        else $error("interrupt does not follow enabled flags");

    done_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        flag_r[`NHIC_XFER_BIT] && !ien_r[`NHIC_XFER_BIT]
        && ((flag_r & ien_r) == 11'h000) |=> !irq)
        else $error("disabled done flag raised the interrupt");

    code_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        flag_r[`NHIC_CODE_BIT] && ien_r[`NHIC_CODE_BIT] |=> irq)
        else $error("enabled mismatch flag missed the interrupt");

    // checks on the flash cycles
    cmd_cycle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_cmd && !gen_busy
        |=> flash_cle && flash_io_oe && flash_io_out == $past(bus_wdata[7:0])
        ##1 !flash_we_n ##[1:4] flash_we_n && flash_cle)
        else $error("command write did not produce a command cycle");

    addr_cycle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_addr && !gen_busy
        |=> flash_ale && !flash_cle && flash_io_out == $past(bus_wdata[7:0])
        ##1 !flash_we_n ##[1:4] flash_we_n && flash_ale)
        else $error("address write did not produce an address cycle");

    cycle_ends_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        gen_start |-> ##[3:8] !gen_busy)
        else $error("flash cycle did not finish");
endmodule

// >>> logic/nhic_consts.svh
/*
 * Constants of the flash host interrupt, command and address block:
 * register byte addresses, field positions, reset values, cycle timing.
 * Assumes inclusion by nhic_top.sv, nhic_cycle_gen.sv and the self-checking bench.
 */
`ifndef NHIC_CONSTS_SVH
`define NHIC_CONSTS_SVH

// register byte addresses
`define NHIC_IEN_ADDR    32'hB000D0A8
`define NHIC_STAT_ADDR   32'hB000D0AC
`define NHIC_CMD_ADDR    32'hB000D0B0
`define NHIC_ADDR_ADDR   32'hB000D0B4

// field positions
`define NHIC_XFER_BIT    0
`define NHIC_CODE_BIT    1
`define NHIC_SLOT0_BIT   8
`define NHIC_SLOT1_BIT   9
`define NHIC_RISE_BIT    10
`define NHIC_LVL0_BIT    16
`define NHIC_LVL1_BIT    17
`define NHIC_LVLRB_BIT   18
`define NHIC_LAST_BIT    31

// flag layout and reset values
`define NHIC_FLAG_MASK   11'h703
`define NHIC_IEN_RST     11'h000
`define NHIC_FLAG_RST    11'h000

// flash strobe timing at the core clock rate
`define NHIC_CLK_MHZ     20
`define NHIC_WE_LOW_NS   100
`define NHIC_HOLD_NS     50
`define NHIC_WE_LOW_CYC  ((`NHIC_WE_LOW_NS * `NHIC_CLK_MHZ + 999) / 1000)
`define NHIC_HOLD_CYC    ((`NHIC_HOLD_NS * `NHIC_CLK_MHZ + 999) / 1000)

`endif

// >>> logic/nhic_pkg.sv
/*
 * Types of the flash host interrupt, command and address block.
 * Assumes nothing of its surroundings.
 */
package nhic_pkg;
    // flash bus cycle sequencer states
    typedef enum logic [1:0] {
        NHIC_IDLE,
        NHIC_SETUP,
        NHIC_STROBE,
        NHIC_HOLD
    } nhic_state_t;
endpackage

// >>> logic/nhic_cycle_gen.sv
/*
 * Flash bus cycle generator: one command or address cycle per start,
 * with the address latch enable held across a multi-byte address.
 * Assumes start only while busy is low; all inputs on core_clk.
 */
`timescale 1ns/1ps
`include "nhic_consts.svh"

module nhic_cycle_gen
    import nhic_pkg::*;
(
    input  wire logic       core_clk,   // core clock
    input  wire logic       rst_n,      // sync reset, active low
    input  wire logic       start,      // begin one cycle
    input  wire logic       is_addr,    // address cycle, else command
    input  wire logic       last,       // final address byte
    input  wire logic [7:0] data,       // byte to place on the bus
    output logic            busy,       // cycle in progress
    output logic            cle_o,      // command latch enable
    output logic            ale_o,      // address latch enable
    output logic            we_n_o,     // write strobe, active low
    output logic [7:0]      io_o,       // bus byte
    output logic            io_oe       // bus driven
);
    nhic_state_t state_r;
    logic [3:0]  cnt_r;
    logic        ale_hold_r;
    logic        cur_addr_r;
    logic        cur_last_r;
    logic        done;

    assign busy = (state_r != NHIC_IDLE);
    assign done = (state_r == NHIC_HOLD) && (cnt_r == 4'h0);

    // sequencer and its strobe counter
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_r <= NHIC_IDLE;
            cnt_r   <= 4'h0;
        end else begin
            unique case (state_r)
                NHIC_IDLE: if (start) state_r <= NHIC_SETUP;
                NHIC_SETUP: begin
                    state_r <= NHIC_STROBE;
                    cnt_r   <= 4'(`NHIC_WE_LOW_CYC - 1);
                end
                NHIC_STROBE: begin
                    if (cnt_r == 4'h0) begin
                        state_r <= NHIC_HOLD;
                        cnt_r   <= 4'(`NHIC_HOLD_CYC - 1);
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                NHIC_HOLD: begin
                    if (cnt_r == 4'h0) state_r <= NHIC_IDLE;
                    else cnt_r <= cnt_r - 4'h1;
                end
            endcase
        end
    end

    // address latch hold: first non-final byte opens it, final closes it
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ale_hold_r <= 1'b0;
            cur_addr_r <= 1'b0;
            cur_last_r <= 1'b0;
        end else if (start && !busy) begin
            cur_addr_r <= is_addr;
            cur_last_r <= last;
            if (is_addr && !last) ale_hold_r <= 1'b1;
        end else if (done && cur_addr_r && cur_last_r) begin
            ale_hold_r <= 1'b0;
        end
    end

    // pin drivers, all registered
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cle_o  <= 1'b0;
            ale_o  <= 1'b0;
            we_n_o <= 1'b1;
            io_o   <= 8'h00;
            io_oe  <= 1'b0;
        end else if (start && !busy) begin
            cle_o <= !is_addr;
            ale_o <= is_addr || ale_hold_r;
            io_o  <= data;
            io_oe <= 1'b1;
        end else if (state_r == NHIC_SETUP) begin
            we_n_o <= 1'b0;
        end else if (state_r == NHIC_STROBE && cnt_r == 4'h0) begin
            we_n_o <= 1'b1; // flash latches on this rising edge
        end else if (done) begin
            cle_o <= 1'b0;
            io_oe <= 1'b0;
            // final byte drops the latch enable once it has gone out
            ale_o <= ale_hold_r && !(cur_addr_r && cur_last_r);
        end
    end

    last_ale_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        done && cur_addr_r && cur_last_r |=> !ale_o && !ale_hold_r)
        else $error("latch enable still high after final address byte");
    open_ale_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        start && !busy && is_addr && !last |=> ale_o ##1 ale_hold_r && !we_n_o)
        else $error("latch enable not raised by non-final address byte");
endmodule

// >>> dv/nhic_flash_model.sv
/*
 * Behavioural flash part and two card sockets for the interrupt,
 * command and address block. Assumes registered host strobes on core_clk.
 */
`timescale 1ns/1ps

module nhic_flash_model (
    input  wire logic        core_clk,   // core clock
    input  wire logic        rst_n,      // sync reset, active low
    input  wire logic        flash_cle,  // command latch enable
    input  wire logic        flash_ale,  // address latch enable
    input  wire logic        flash_we_n, // write strobe, active low
    input  wire logic [7:0]  flash_io,   // bus byte from host
    input  wire logic        flash_oe,   // host drives the bus
    input  wire logic [7:0]  busy_len,   // busy cycles after a command
    input  wire logic        card0_in,   // card present in slot 0
    input  wire logic        card1_in,   // card present in slot 1
    output logic             ready_busy, // ready high, busy low
    output logic             slot0_det,  // slot 0 detect level
    output logic             slot1_det,  // slot 1 detect level
    output logic [7:0]       cap_count,  // bytes latched so far
    output logic [10:0]      cap_word    // oe, cle, ale, byte of last latch
);
    logic       we_q;
    logic [7:0] busy_cnt;

    // latch on the rising write strobe, like a real part
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            we_q      <= 1'h1;
            cap_count <= 8'h00;
            cap_word  <= 11'h000;
        end else begin
            we_q <= flash_we_n;
            if (flash_we_n && !we_q) begin
                cap_count <= cap_count + 8'h01;
                cap_word  <= {flash_oe, flash_cle, flash_ale, flash_io};
            end
        end
    end

    // a latched command makes the part busy for a while
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            busy_cnt <= 8'h00;
        end else if (flash_we_n && !we_q && flash_cle) begin
            busy_cnt <= busy_len;
        end else if (busy_cnt != 8'h00) begin
            busy_cnt <= busy_cnt - 8'h01;
        end
    end

    // pin reads ready whenever the busy count is zero, so an idle part reads ready
    assign ready_busy = (busy_cnt == 8'h00);
    assign slot0_det  = card0_in;
    assign slot1_det  = card1_in;
endmodule

// >>> dv/nhic_top_test.sv
/*
 * Self-checking bench for nhic_top with the flash and socket model.
 * Assumes the register map and cycle timing of the constants header.
 */
`timescale 1ns/1ps
`include "nhic_consts.svh"

module nhic_top_test;
    logic core_clk, rst_n, bus_wr, bus_rd, xfer_done, code_mismatch;
    logic [31:0] bus_addr, bus_wdata, bus_rdata, d;
    logic rb, det0, det1, irq, cle, ale, we_n, oe;
    logic [7:0] io, busy_len, cap_count;
    logic [10:0] cap_word;
    logic [1:0] card;
    int bad_count, compares;

    nhic_top dut (.core_clk(core_clk), .rst_n(rst_n), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .xfer_done(xfer_done), .code_mismatch(code_mismatch), .ready_busy_pin(rb),
        .slot0_detect_pin(det0), .slot1_detect_pin(det1), .irq(irq), .flash_cle(cle),
        .flash_ale(ale), .flash_we_n(we_n), .flash_io_out(io), .flash_io_oe(oe));
    nhic_flash_model flash (.core_clk(core_clk), .rst_n(rst_n), .flash_cle(cle),
        .flash_ale(ale), .flash_we_n(we_n), .flash_io(io), .flash_oe(oe),
        .busy_len(busy_len), .card0_in(card[0]), .card1_in(card[1]), .ready_busy(rb),
        .slot0_det(det0), .slot1_det(det1), .cap_count(cap_count), .cap_word(cap_word));

    // free-running core clock, 50 ns period
    always #25 core_clk = ~core_clk;

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // one-cycle write strobe beside address and data
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge core_clk);
        bus_addr  <= a;
        bus_wdata <= v;
        bus_wr    <= 1'h1;
        @(posedge core_clk);
        bus_wr <= 1'h0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rchk(input string w, input logic [31:0] a, m, e);
        @(posedge core_clk);
        bus_addr <= a;
        bus_rd   <= 1'h1;
        @(posedge core_clk);
        bus_rd <= 1'h0;
        #1 d = bus_rdata;
        chk(w, e & m, d & m);
    endtask

    // port write, then wait for the part to latch it, bounded
    task automatic pwr(input logic [31:0] a, v, input logic [10:0] e);
        logic [7:0] n;
        int k;
        n = cap_count;
        wr(a, v);
        for (k = 0; k < 20 && cap_count == n; k++) @(posedge core_clk);
        if (k == 20) begin
            bad_count++;
            tally_and_finish();
        end
        chk("latched cycle", {21'h0, e}, {21'h0, cap_word});
        cyc(3);
    endtask

    task automatic t_reset;
        rchk("status", `NHIC_STAT_ADDR, 32'hFFFFFFFF, 32'h00050000);
        rchk("enable", `NHIC_IEN_ADDR, 32'hFFFFFFFF, 32'h0);
        rchk("command port", `NHIC_CMD_ADDR, 32'hFFFFFFFF, 32'h0);
        rchk("unmapped", 32'hB000D0B8, 32'hFFFFFFFF, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        $display("test reset done");
    endtask

    task automatic t_enable;
        wr(`NHIC_IEN_ADDR, 32'hFFFFFFFF);
        rchk("enable", `NHIC_IEN_ADDR, 32'hFFFFFFFF, 32'h00000703);
        wr(`NHIC_IEN_ADDR, 32'h0);
        rchk("enable", `NHIC_IEN_ADDR, 32'hFFFFFFFF, 32'h0);
        $display("test enable done");
    endtask

    // transfer done and code mismatch flags, gating and clearing
    task automatic t_events;
        logic [31:0] b;
        for (int i = 0; i < 2; i++) begin
            b = 32'h1 << i;
            @(posedge core_clk);
            if (i == 0) xfer_done <= 1'h1;
            else code_mismatch <= 1'h1;
            @(posedge core_clk);
            xfer_done     <= 1'h0;
            code_mismatch <= 1'h0;
            cyc(3);
            rchk("event flag", `NHIC_STAT_ADDR, b, b);
            chk("irq masked", 32'h0, {31'h0, irq});
            wr(`NHIC_IEN_ADDR, b);
            cyc(3);
            chk("irq enabled", 32'h1, {31'h0, irq});
            wr(`NHIC_STAT_ADDR, ~b);
            rchk("flag kept", `NHIC_STAT_ADDR, b, b);
            wr(`NHIC_STAT_ADDR, b);
            cyc(3);
            rchk("flag cleared", `NHIC_STAT_ADDR, b, 32'h0);
            chk("irq dropped", 32'h0, {31'h0, irq});
            wr(`NHIC_IEN_ADDR, 32'h0);
        end
        $display("test events done");
    endtask

    // card changes recorded only while the slot's enable is set
    task automatic t_slots;
        logic [31:0] f, l;
        for (int s = 0; s < 2; s++) begin
            f = 32'h100 << s;
            l = 32'h10000 << s;
            card[s] <= ~card[s];
            cyc(8);
            rchk("slot ignored", `NHIC_STAT_ADDR, f | l, card[s] ? l : 32'h0);
            wr(`NHIC_IEN_ADDR, f);
            card[s] <= ~card[s];
            cyc(8);
            rchk("slot change", `NHIC_STAT_ADDR, f | l, card[s] ? f | l : f);
            chk("irq slot", 32'h1, {31'h0, irq});
            wr(`NHIC_STAT_ADDR, f);
            cyc(3);
            rchk("slot cleared", `NHIC_STAT_ADDR, f, 32'h0);
            wr(`NHIC_IEN_ADDR, 32'h0);
        end
        $display("test slots done");
    endtask

    // command, busy period, ready rise, then a three byte address
    task automatic t_flash;
        busy_len <= 8'h14;
        pwr(`NHIC_CMD_ADDR, 32'h00000090, 11'h690);
        rchk("busy level", `NHIC_STAT_ADDR, 32'h00040400, 32'h0);
        cyc(30);
        rchk("ready rise", `NHIC_STAT_ADDR, 32'h00040400, 32'h00040400);
        wr(`NHIC_IEN_ADDR, 32'h00000400);
        cyc(3);
        chk("irq ready", 32'h1, {31'h0, irq});
        wr(`NHIC_STAT_ADDR, 32'h00000400);
        wr(`NHIC_IEN_ADDR, 32'h0);
        pwr(`NHIC_ADDR_ADDR, 32'h00000012, 11'h512);
        chk("ale held", 32'h1, {31'h0, ale});
        pwr(`NHIC_ADDR_ADDR, 32'h00000034, 11'h534);
        chk("ale held", 32'h1, {31'h0, ale});
        pwr(`NHIC_ADDR_ADDR, 32'h80000056, 11'h556);
        chk("ale dropped", 32'h0, {31'h0, ale});
        $display("test flash done");
    endtask

    initial begin
        core_clk = 1'h0;
        rst_n = 1'h0;
        bus_wr = 1'h0;
        bus_rd = 1'h0;
        bus_addr = 32'h0;
        bus_wdata = 32'h0;
        xfer_done = 1'h0;
        code_mismatch = 1'h0;
        busy_len = 8'h00;
        card = 2'h1;
        bad_count = 0;
        compares = 0;
        cyc(8);
        rst_n <= 1'h1;
        cyc(5);
        t_reset();
        t_enable();
        t_events();
        t_slots();
        t_flash();
        tally_and_finish();
    end
endmodule
